// >>> common/acr_pkg.sv
// Shared constants for the converter control and calibration registers
package acr_pkg;
  // Register byte offsets
  localparam logic [7:0] ACR_OFF_CTRL = 8'h00;
  localparam logic [7:0] ACR_OFF_DATA = 8'h04;
  localparam logic [7:0] ACR_OFF_OCAL = 8'h08;
  localparam logic [7:0] ACR_OFF_PCAL = 8'h0c;
  localparam logic [7:0] ACR_OFF_NCAL = 8'h10;
  // Control field positions
  localparam int ACR_B_BITORD  = 0;  // 0: msb first
  localparam int ACR_B_BYTEORD = 1;  // 0: descending bytes
  localparam int ACR_B_PINMODE = 2;  // 0: one bidirectional pin
  localparam int ACR_B_CODING  = 3;  // 0: offset binary
  localparam int ACR_B_UNIPOL  = 4;  // 0: bipolar
  localparam int ACR_B_GAIN    = 5;  // 3 bits, 0: gain 1
  localparam int ACR_B_MODE    = 8;  // 3 bits
  localparam int ACR_B_BURN    = 11; // 0: burn-out current off
  localparam int ACR_B_SLEEP   = 12; // 0: awake
  localparam int ACR_B_NOTCH   = 13; // 11 bits, notch in Hz
  // Operating mode codes
  localparam logic [2:0] ACR_MODE_CONV = 3'h0;
  localparam logic [2:0] ACR_MODE_SELF = 3'h1;
  localparam logic [10:0] ACR_NOTCH_RST = 11'd30;
  // Control value after reset
  localparam logic [23:0] ACR_CTRL_RST =
    {ACR_NOTCH_RST, 2'b00, ACR_MODE_SELF, 3'h0, 5'h00};
  // Calibration values after reset (neutral)
  localparam logic [23:0] ACR_OCAL_RST = 24'h000000;
  localparam logic [23:0] ACR_FS_RST   = 24'h800000;
  localparam logic [23:0] ACR_MSB      = 24'h800000;
  localparam int ACR_FS_SHIFT = 23;
  // AXI responses
  localparam logic [1:0] ACR_RESP_OKAY   = 2'b00;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'b10;
endpackage

// >>> common/acr_cal_if.sv
// Carrier between register block and calibration datapath
`timescale 1ns/1ps
`default_nettype none
interface acr_cal_if;
  logic              raw_valid;  // New raw conversion
  logic signed [23:0] raw;       // Raw two's complement sample
  logic [23:0]       ocal;       // Offset calibration
  logic [23:0]       pcal;       // Positive full scale
  logic [23:0]       ncal;       // Negative full scale
  logic              unipolar;   // Unipolar range select
  logic              res_valid;  // Corrected result strobe
  logic signed [23:0] res;       // Corrected result
  modport regs (output raw_valid, raw, ocal, pcal, ncal, unipolar,
                input res_valid, res);
  modport cal  (input raw_valid, raw, ocal, pcal, ncal, unipolar,
                output res_valid, res);
endinterface
`default_nettype wire

// >>> verilog/acr_cal.sv
// Calibration correction datapath, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module acr_cal
  import acr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  acr_cal_if.cal   cif
);
  logic signed [24:0] diff;   // Raw minus offset
  logic        [23:0] fs;     // Selected full scale
  logic signed [49:0] prod;   // Scaled value
  logic signed [49:0] shr;    // Normalised value

  // Offset removal and gain scaling; neutral values give raw back
  always_comb begin
    diff = 25'(cif.raw) - 25'(signed'(cif.ocal));
    // Unipolar uses positive full scale only
    fs   = (cif.unipolar || !diff[24]) ? cif.pcal : cif.ncal;
    prod = 50'(diff) * 50'(signed'({1'b0, fs}));
    shr  = prod >>> ACR_FS_SHIFT;
  end

  // Saturate and register the result
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cif.res_valid <= 1'b0;
      cif.res       <= '0;
    end else begin
      cif.res_valid <= cif.raw_valid;
      if (cif.raw_valid) begin
        if (shr > 50'sh7fffff)
          cif.res <= 24'sh7fffff;      // Positive clip
        else if (shr < -50'sh800000)
          cif.res <= 24'sh800000;      // Negative clip
        else
          cif.res <= shr[23:0];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/acr_top.sv
// Converter control and calibration register block, AXI4-Lite slave
//
// Contract
// [RULE1] Reset: offset binary, 30Hz, self-cal, gain 1, bipolar
// [RULE2] Reset: burn-out current and sleep inactive
// [RULE3] Reset: msb first, descending bytes, bidirectional pin
// [RULE4] Framing in low three control bits, zero default
// [RULE5] Bipolar: zero offset, 800000 scales bypass
// [RULE6] Unipolar: zero offset, 800000 positive bypasses
// [RULE7] Registers three bytes, written whole
// [RULE8] Data read gives latest result, current coding
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module acr_top
  import acr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Raw conversion from the modulator filter
  input  wire logic        conv_valid,
  input  wire logic [23:0] conv_raw,
  // Control fields to the converter core
  output logic             lsb_first,
  output logic             ascending_bytes,
  output logic             unidir_pins,
  output logic             twos_coding,
  output logic             unipolar,
  output logic [2:0]       gain_sel,
  output logic [2:0]       op_mode,
  output logic             burnout_en,
  output logic             sleep_en,
  output logic [10:0]      notch_hz
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [23:0] ctrl_reg;     // Control word
  logic [23:0] ocal_reg;     // Offset calibration
  logic [23:0] pcal_reg;     // Positive full scale calibration
  logic [23:0] ncal_reg;     // Negative full scale calibration
  logic [23:0] data_reg;     // Latest corrected result, two's complement
  logic        aw_hold_reg;  // Write address taken
  logic [7:0]  awaddr_reg;   // Held write address
  logic        w_hold_reg;   // Write data taken
  logic [31:0] wdata_reg;    // Held write data
  logic [3:0]  wstrb_reg;    // Held strobes
  logic        do_write;     // Both halves present
  logic        wr_ok;        // Write lands in a register
  logic [31:0] rd_next;      // Read mux
  logic        rd_ok;        // Read address mapped

  acr_cal_if cif ();

  ////////////////////////////////////////////////////////////////////////
  // Calibration datapath
  acr_cal u_cal (
    .clock (clock),
    .rst_n (rst_n),
    .cif   (cif)
  );

  // Feed raw samples and calibration values
  assign cif.raw_valid = conv_valid;
  assign cif.raw       = signed'(conv_raw);
  assign cif.ocal      = ocal_reg;              // RULE5
  assign cif.pcal      = pcal_reg;              // RULE5
  assign cif.ncal      = ncal_reg;              // RULE5
  assign cif.unipolar  = ctrl_reg[ACR_B_UNIPOL]; // RULE6

  ////////////////////////////////////////////////////////////////////////
  // Write channel capture
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  // Address capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  // Data capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  // Ready while nothing held on that channel and no write response pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid && !do_write;
      s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid && !do_write;
    end
  end

  // Write decode: all three low bytes required
  always_comb begin
    wr_ok = (wstrb_reg[2:0] == 3'b111);           // RULE7
    unique case (awaddr_reg)
      ACR_OFF_CTRL, ACR_OFF_OCAL,
      ACR_OFF_PCAL, ACR_OFF_NCAL: wr_ok = wr_ok;
      default:                    wr_ok = 1'b0;    // Unmapped or read-only
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= ACR_CTRL_RST;                    // RULE1 RULE2 RULE3
    end else if (do_write && wr_ok && awaddr_reg == ACR_OFF_CTRL) begin
      ctrl_reg <= wdata_reg[23:0];                 // RULE4 RULE7
    end
  end

  // Calibration registers, neutral after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ocal_reg <= ACR_OCAL_RST;
      pcal_reg <= ACR_FS_RST;
      ncal_reg <= ACR_FS_RST;
    end else if (do_write && wr_ok) begin
      if (awaddr_reg == ACR_OFF_OCAL)
        ocal_reg <= wdata_reg[23:0];               // RULE7
      if (awaddr_reg == ACR_OFF_PCAL)
        pcal_reg <= wdata_reg[23:0];
      if (awaddr_reg == ACR_OFF_NCAL)
        ncal_reg <= wdata_reg[23:0];
    end
  end

  // Write response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ACR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion result capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_reg <= '0;
    end else if (cif.res_valid) begin
      data_reg <= cif.res;                         // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    rd_ok   = 1'b1;
    rd_next = '0;
    unique case (s_axi_araddr)
      ACR_OFF_CTRL: rd_next = {8'h00, ctrl_reg};
      // Coding applied at read time from the current setting
      ACR_OFF_DATA: rd_next = {8'h00, ctrl_reg[ACR_B_CODING] ?
                               data_reg : data_reg ^ ACR_MSB}; // RULE8
      ACR_OFF_OCAL: rd_next = {8'h00, ocal_reg};
      ACR_OFF_PCAL: rd_next = {8'h00, pcal_reg};
      ACR_OFF_NCAL: rd_next = {8'h00, ncal_reg};
      default:      rd_ok   = 1'b0;                // Unmapped
    endcase
  end

  // Read address ready while no answer pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // Read answer one cycle after the address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ACR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_next;
      s_axi_rresp  <= rd_ok ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control fields out, registered copies of the control word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lsb_first       <= 1'b0;                     // RULE3
      ascending_bytes <= 1'b0;                     // RULE3
      unidir_pins     <= 1'b0;                     // RULE3
      twos_coding     <= 1'b0;                     // RULE1
      unipolar        <= 1'b0;                     // RULE1
      gain_sel        <= 3'h0;                     // RULE1
      op_mode         <= ACR_MODE_SELF;            // RULE1
      burnout_en      <= 1'b0;                     // RULE2
      sleep_en        <= 1'b0;                     // RULE2
      notch_hz        <= ACR_NOTCH_RST;            // RULE1
    end else begin
      lsb_first       <= ctrl_reg[ACR_B_BITORD];   // RULE4
      ascending_bytes <= ctrl_reg[ACR_B_BYTEORD];  // RULE4
      unidir_pins     <= ctrl_reg[ACR_B_PINMODE];  // RULE4
      twos_coding     <= ctrl_reg[ACR_B_CODING];
      unipolar        <= ctrl_reg[ACR_B_UNIPOL];
      gain_sel        <= ctrl_reg[ACR_B_GAIN +: 3];
      op_mode         <= ctrl_reg[ACR_B_MODE +: 3];
      burnout_en      <= ctrl_reg[ACR_B_BURN];
      sleep_en        <= ctrl_reg[ACR_B_SLEEP];
      notch_hz        <= ctrl_reg[ACR_B_NOTCH +: 11];
    end
  end

endmodule
`default_nettype wire

// >>> sim/acr_top_monitor.sv
// Bus and control output checker for the register block
`timescale 1ns/1ps
`default_nettype none
module acr_check
  import acr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        lsb_first,
  input wire logic        ascending_bytes,
  input wire logic        unidir_pins,
  input wire logic        twos_coding,
  input wire logic        unipolar,
  input wire logic [2:0]  gain_sel,
  input wire logic [2:0]  op_mode,
  input wire logic        burnout_en,
  input wire logic        sleep_en,
  input wire logic [10:0] notch_hz
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Control outputs gathered in register order
  wire logic [23:0] cfg = {notch_hz, sleep_en, burnout_en, op_mode, gain_sel, unipolar,
                           twos_coding, unidir_pins, ascending_bytes, lsb_first};
  reset_mode_a: assert property (
    !$past(rst_n) |-> cfg[10:3] == ACR_CTRL_RST[10:3] && notch_hz == 11'd30)
    else $error("mode fields not at reset value");
  reset_power_a: assert property (!$past(rst_n) |-> !burnout_en && !sleep_en)
    else $error("burn-out or sleep active after reset");
  reset_frame_a: assert property (!$past(rst_n) |-> cfg[2:0] == 3'h0)
    else $error("framing bits set after reset");
  cfg_by_write_a: assert property (
    $changed(cfg) |-> $past(s_axi_bvalid) && $past(s_axi_bresp) == ACR_RESP_OKAY)
    else $error("control changed without accepted write");
  resp_cause_a: assert property (
    $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready, 2)
                            || $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("write response without transfer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  read_top_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
    else $error("upper read byte not zero");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after acceptance");
endmodule
`default_nettype wire

// >>> sim/acr_conv_src.sv
// Raw sample source standing in for the modulator filter
`timescale 1ns/1ps
`default_nettype none
module acr_conv_src (
  input wire logic   clock,
  output logic        conv_valid,
  output logic [23:0] conv_raw
);
  initial begin
    conv_valid = 1'b0;
    conv_raw = 24'h000000;
  end
  // One-cycle pulse; sample bus scrambled once released
  task automatic send(input logic [23:0] v);
    @(posedge clock);
    conv_valid <= 1'b1;
    conv_raw <= v;
    @(posedge clock);
    conv_valid <= 1'b0;
    conv_raw <= ~v;
  endtask
endmodule
`default_nettype wire

// >>> sim/acr_top_bench.sv
// Register access tests for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module acr_top_bench
  import acr_pkg::*;
;
  logic        clock = 1'b0, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, conv_valid, lsb_first, ascending_bytes;
  logic        unidir_pins, twos_coding, unipolar, burnout_en, sleep_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] conv_raw;
  logic [2:0]  gain_sel, op_mode;
  logic [10:0] notch_hz;
  // Control outputs except burn-out and sleep, in register order, framing bits lowest
  wire logic [21:0] cfg_seen = {notch_hz, op_mode, gain_sel, unipolar, twos_coding,
                                unidir_pins, ascending_bytes, lsb_first};
  int          miscompares = 0, tests_run = 0;
  always #5 clock = ~clock;
  acr_top acr_top_i (.*);
  acr_conv_src acr_conv_src_i (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge clock);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  // Bus read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'b11, a};
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  // One conversion, then time for the result to land
  task automatic cv(input logic [23:0] v);
    acr_conv_src_i.send(v);
    repeat (3) @(posedge clock);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} <= '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    `CHK("frame", 3'h0, {unidir_pins, ascending_bytes, lsb_first})
    `CHK("power", 2'h0, {sleep_en, burnout_en})
    `CHK("mode", {11'd30, 3'h1, 5'h0}, cfg_seen[21:3])
    rd(ACR_OFF_CTRL, 32'h0003c100, ACR_RESP_OKAY);
    rd(ACR_OFF_OCAL, 32'h00000000, ACR_RESP_OKAY);
    rd(ACR_OFF_PCAL, 32'h00800000, ACR_RESP_OKAY);
    rd(ACR_OFF_NCAL, 32'h00800000, ACR_RESP_OKAY);
    rd(ACR_OFF_DATA, 32'h00800000, ACR_RESP_OKAY);
    cv(24'h123456);
    rd(ACR_OFF_DATA, 32'h00923456, ACR_RESP_OKAY);
    cv(24'hf00000);
    rd(ACR_OFF_DATA, 32'h00700000, ACR_RESP_OKAY);
    wr(ACR_OFF_CTRL, 32'h00014008, 4'hf, ACR_RESP_OKAY);
    rd(ACR_OFF_DATA, 32'h00f00000, ACR_RESP_OKAY);
    `CHK("cfg", {11'd10, 3'h0, 5'h1, 3'h0}, cfg_seen)
    wr(ACR_OFF_CTRL, 32'h00015848, 4'hf, ACR_RESP_OKAY);
    rd(ACR_OFF_CTRL, 32'h00015848, ACR_RESP_OKAY);
    `CHK("burn_sleep", 2'h3, {sleep_en, burnout_en})
    `CHK("gain", 3'h2, gain_sel)
    wr(ACR_OFF_NCAL, 32'h00000123, 4'hf, ACR_RESP_OKAY);
    wr(ACR_OFF_CTRL, 32'h00014018, 4'hf, ACR_RESP_OKAY);
    cv(24'hff0000);
    rd(ACR_OFF_DATA, 32'h00ff0000, ACR_RESP_OKAY);
    wr(ACR_OFF_OCAL, 32'hff000008, 4'hf, ACR_RESP_OKAY);
    rd(ACR_OFF_OCAL, 32'h00000008, ACR_RESP_OKAY);
    wr(ACR_OFF_OCAL, 32'h00000555, 4'h3, ACR_RESP_SLVERR);
    rd(ACR_OFF_OCAL, 32'h00000008, ACR_RESP_OKAY);
    wr(ACR_OFF_DATA, 32'h00000001, 4'hf, ACR_RESP_SLVERR);
    rd(8'h14, 32'h00000000, ACR_RESP_SLVERR);
    finish_test();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    finish_test();
  end
endmodule
bind acr_top acr_check acr_check_i (.*);
`default_nettype wire
